// ==== hw/purs_pkg.sv ====
// Package of constants, register map and state types for the power-up reset sequencer
package purs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int OSC_CHECK_CYC   = 1032;
  localparam int FUSE_LOAD_CYC   = 1160;
  localparam int PUMP_UP_CYC     = 688;
  localparam int BANK_UP_CYC     = 617;
  localparam int WARM_POR_CYC    = 2256;
  localparam int WARM_OTHER_PCLK = 32;
  localparam int FILT_MIN_NS     = 475;
  localparam int FILT_MAX_NS     = 2000;
  // Least time rounds up, longest time rounds down
  localparam int FILT_MIN_CYC    = (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_MAX_CYC    = FILT_MAX_NS / CLK_PERIOD_NS;
  // Filter accepts a low level held this many cycles
  localparam int FILT_ACCEPT_CYC = FILT_MIN_CYC + 1;
  localparam int PCLK_DIV        = 4;
  localparam logic [31:0] CPU_BOOT_ADDR = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_EXC_STATUS  = 12'h000;
  localparam logic [11:0] ADDR_GLB_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_RESET_CTRL  = 12'h008;
  localparam logic [11:0] ADDR_SEQ_STATUS  = 12'h00C;

  localparam int EXC_POWERUP_BIT = 15;
  localparam int EXC_WDOG_BIT    = 13;
  localparam int EXC_SELFTST_BIT = 5;
  localparam int EXC_SWRST_BIT   = 4;
  localparam int EXC_EXTRST_BIT  = 3;
  localparam int GLB_OSCFAIL_BIT = 0;
  localparam int GLB_SLIP0_BIT   = 8;
  localparam int GLB_SLIP1_BIT   = 9;
  localparam int CTRL_SWRST_BIT  = 0;

  localparam logic [15:0] EXC_RESET = 16'h0000;
  localparam logic [15:0] GLB_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PURS_WAIT_SUPPLY, PURS_OSC_CHECK, PURS_FUSE_LOAD, PURS_PUMP_UP, PURS_BANK_UP, PURS_RUN
  } purs_phase_t;

  // Internal reset event sources
  typedef struct packed {
    logic oscFail;
    logic pllSlip0;
    logic pllSlip1;
    logic watchdog;
    logic selfTest;
  } purs_events_t;

  // APB slave request
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } purs_apb_req_t;

endpackage

// ==== hw/purs_glitch_filter.sv ====
// Low-pulse glitch filter for an active-low reset input
`timescale 1ns/1ps
module purs_glitch_filter #(
  parameter int ACCEPT_CYC = purs_pkg::FILT_ACCEPT_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic rawInN,
  output logic      filtLow
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       low;
  } purs_filt_st_t;

  purs_filt_st_t st;
  purs_filt_st_t next_st;

  // Count consecutive low cycles; short lows are discarded
  always_comb begin
    next_st = st;
    if (rawInN) begin
      next_st.cnt = 8'h00;
      next_st.low = 1'b0;
    end else if (st.cnt >= 8'(ACCEPT_CYC - 1)) begin
      next_st.low = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filtLow = st.low;

endmodule

// ==== hw/purs_sequencer.sv ====
// Power-up reset sequencer with cause flags and APB status registers
//
// What this block does
// - After power-on release, wait 1032 cycles for oscillator check first.
// - Then fuse autoload 1160, flash pump 688, flash bank 617, in order.
// - Release CPU reset only after last phase; boot address is zero (this block has no boot address output; CPU_BOOT_ADDR is unused).
// - Start only with both supplies good and power-on reset released.
// - Power-on input filter drops lows under 475 ns, accepts over 2000 ns.
// - Warm reset pin input is filtered the same way.
// - Warm reset pin is open drain, driven low on any internal reset.
// - After power-on release, drive warm reset low at least 2256 cycles.
// - Other causes drive warm reset low at least 32 peripheral clocks.
// - Power-up reset sets exception status bit 15.
// - Oscillator failure sets global status bit 0.
// - PLL slip sets global status bits 8 and 9.
// - Watchdog or debugger reset sets exception status bit 13.
// - Self-test controller CPU reset sets exception status bit 5.
// - Software reset sets exception status bit 4.
// - External warm reset low sets exception status bit 3.
// - Core supply fault tristates outputs and forces power-on reset.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module purs_sequencer #(
  parameter int OSC_CHECK_CYC = purs_pkg::OSC_CHECK_CYC,
  parameter int FUSE_LOAD_CYC = purs_pkg::FUSE_LOAD_CYC,
  parameter int PUMP_UP_CYC   = purs_pkg::PUMP_UP_CYC,
  parameter int BANK_UP_CYC   = purs_pkg::BANK_UP_CYC,
  parameter int WARM_POR_CYC  = purs_pkg::WARM_POR_CYC,
  parameter int PCLK_DIV      = purs_pkg::PCLK_DIV
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   power_on_reset_in_n,
  input  wire logic                   core_power_good,
  input  wire logic                   io_power_good,
  input  wire logic                   warm_reset_pin_n_in,
  output logic                        warm_reset_pin_n_out,
  output logic                        warm_reset_pin_n_oe,
  input  wire purs_pkg::purs_events_t resetEvents,
  input  wire logic                   debugReset,
  output logic                        cpuReset,
  output logic                        outputsHiZ,
  input  wire purs_pkg::purs_apb_req_t apbReq,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    purs_pkg::purs_phase_t phase;
    logic [11:0] phaseCnt;
    logic [11:0] holdCnt;
    logic [2:0]  pclkDiv;
    logic        pclkEn;
    logic        warmLow;
    logic        warmLowD;
    logic        pinDrive;
    logic        cpuRst;
    logic        hiZ;
    logic        extSeen;
    logic [15:0] excStatus;
    logic [15:0] glbStatus;
    logic        swReq;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } purs_seq_st_t;

  purs_seq_st_t st;
  purs_seq_st_t next_st;

  logic porLow;
  logic extLow;
  logic supplyOk;
  logic internalEvt;
  logic extFromBoard;
  logic apbAccess;
  logic apbWr;
  logic apbRd;

  // ----------------------------------------------------------------
  // Input filters
  // ----------------------------------------------------------------
  purs_glitch_filter #(.ACCEPT_CYC(purs_pkg::FILT_ACCEPT_CYC)) u_por_filter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rawInN  (power_on_reset_in_n),
    .filtLow (porLow)
  );

  purs_glitch_filter #(.ACCEPT_CYC(purs_pkg::FILT_ACCEPT_CYC)) u_warm_filter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rawInN  (warm_reset_pin_n_in),
    .filtLow (extLow)
  );

  // Supply good and power-on release gate the sequence
  assign supplyOk    = core_power_good & io_power_good & ~porLow;
  assign internalEvt = (|resetEvents) | debugReset | st.swReq;
  // Echo of our own pin drive is masked until the filter has cleared
  assign extFromBoard = extLow & ~(st.warmLow | st.warmLowD);
  assign apbAccess   = apbReq.psel & apbReq.penable & ~st.ready;
  assign apbWr       = apbAccess & apbReq.pwrite;
  assign apbRd       = apbAccess & ~apbReq.pwrite;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Peripheral clock enable divider
    next_st.pclkEn = 1'b0;
    if (st.pclkDiv == 3'(PCLK_DIV - 1)) begin
      next_st.pclkDiv = 3'h0;
      next_st.pclkEn  = 1'b1;
    end else begin
      next_st.pclkDiv = st.pclkDiv + 3'h1;
    end

    // Power-up phase machine
    case (st.phase)
      purs_pkg::PURS_WAIT_SUPPLY: begin
        next_st.phaseCnt = 12'h000;
        if (supplyOk) begin
          next_st.phase = purs_pkg::PURS_OSC_CHECK;
        end
      end
      purs_pkg::PURS_OSC_CHECK: begin
        next_st.phaseCnt = st.phaseCnt + 12'h001;
        if (st.phaseCnt == 12'(OSC_CHECK_CYC - 1)) begin
          next_st.phaseCnt = 12'h000;
          next_st.phase    = purs_pkg::PURS_FUSE_LOAD;
        end
      end
      purs_pkg::PURS_FUSE_LOAD: begin
        next_st.phaseCnt = st.phaseCnt + 12'h001;
        if (st.phaseCnt == 12'(FUSE_LOAD_CYC - 1)) begin
          next_st.phaseCnt = 12'h000;
          next_st.phase    = purs_pkg::PURS_PUMP_UP;
        end
      end
      purs_pkg::PURS_PUMP_UP: begin
        next_st.phaseCnt = st.phaseCnt + 12'h001;
        if (st.phaseCnt == 12'(PUMP_UP_CYC - 1)) begin
          next_st.phaseCnt = 12'h000;
          next_st.phase    = purs_pkg::PURS_BANK_UP;
        end
      end
      purs_pkg::PURS_BANK_UP: begin
        next_st.phaseCnt = st.phaseCnt + 12'h001;
        if (st.phaseCnt == 12'(BANK_UP_CYC - 1)) begin
          next_st.phaseCnt = 12'h000;
          next_st.phase    = purs_pkg::PURS_RUN;
        end
      end
      purs_pkg::PURS_RUN: begin
        next_st.phaseCnt = 12'h000;
      end
      default: begin
        next_st.phase = purs_pkg::PURS_WAIT_SUPPLY;
      end
    endcase

    // Power-on fault restarts the whole sequence
    if (!supplyOk) begin
      next_st.phase   = purs_pkg::PURS_WAIT_SUPPLY;
      next_st.holdCnt = 12'(WARM_POR_CYC);
      next_st.excStatus[purs_pkg::EXC_POWERUP_BIT] = 1'b1;
    end
    next_st.hiZ = ~core_power_good;

    // Warm reset hold after power-on release, counted in clock cycles
    if (supplyOk && st.holdCnt != 12'h000 && st.phase != purs_pkg::PURS_RUN) begin
      next_st.holdCnt = st.holdCnt - 12'h001;
    end

    // Other causes: hold for peripheral clock periods
    if (st.phase == purs_pkg::PURS_RUN) begin
      if (internalEvt || extFromBoard) begin
        // One extra count covers the partial first peripheral period
        next_st.holdCnt = 12'(purs_pkg::WARM_OTHER_PCLK + 1);
      end else if (st.pclkEn && st.holdCnt != 12'h000) begin
        next_st.holdCnt = st.holdCnt - 12'h001;
      end
    end

    // Device drives pin low during power-up phases, on internal events, and for the hold that an external reset also starts
    next_st.warmLow = (st.phase != purs_pkg::PURS_RUN) || internalEvt || (next_st.holdCnt != 12'h000);
    next_st.cpuRst  = (next_st.phase != purs_pkg::PURS_RUN) || next_st.warmLow || extFromBoard;
    next_st.warmLowD = st.warmLow;
    next_st.pinDrive = next_st.warmLow & ~next_st.hiZ;
    next_st.swReq   = 1'b0;

    // External reset seen only when the device is not driving the pin
    next_st.extSeen = extFromBoard;

    // APB slave, one wait state then answer
    next_st.ready  = apbAccess;
    next_st.slverr = 1'b0;
    next_st.rdata  = 32'h0000_0000;
    if (apbWr) begin
      case (apbReq.paddr)
        purs_pkg::ADDR_EXC_STATUS: next_st.excStatus = st.excStatus & ~apbReq.pwdata[15:0];
        purs_pkg::ADDR_GLB_STATUS: next_st.glbStatus = st.glbStatus & ~apbReq.pwdata[15:0];
        purs_pkg::ADDR_RESET_CTRL: next_st.swReq = apbReq.pwdata[purs_pkg::CTRL_SWRST_BIT];
        purs_pkg::ADDR_SEQ_STATUS: next_st.slverr = 1'b0;
        default: next_st.slverr = 1'b1;
      endcase
    end
    if (apbRd) begin
      case (apbReq.paddr)
        purs_pkg::ADDR_EXC_STATUS: next_st.rdata = {16'h0000, st.excStatus};
        purs_pkg::ADDR_GLB_STATUS: next_st.rdata = {16'h0000, st.glbStatus};
        purs_pkg::ADDR_RESET_CTRL: next_st.rdata = 32'h0000_0000;
        purs_pkg::ADDR_SEQ_STATUS: next_st.rdata = {27'h0000000, st.cpuRst, 1'b0, st.phase};
        default: next_st.slverr = 1'b1;
      endcase
    end

    // Cause flags set after the clear so an event wins
    if (!supplyOk) begin
      next_st.excStatus[purs_pkg::EXC_POWERUP_BIT] = 1'b1;
    end
    if (resetEvents.oscFail) begin
      next_st.glbStatus[purs_pkg::GLB_OSCFAIL_BIT] = 1'b1;
    end
    if (resetEvents.pllSlip0) begin
      next_st.glbStatus[purs_pkg::GLB_SLIP0_BIT] = 1'b1;
    end
    if (resetEvents.pllSlip1) begin
      next_st.glbStatus[purs_pkg::GLB_SLIP1_BIT] = 1'b1;
    end
    if (resetEvents.watchdog || debugReset) begin
      next_st.excStatus[purs_pkg::EXC_WDOG_BIT] = 1'b1;
    end
    if (resetEvents.selfTest) begin
      next_st.excStatus[purs_pkg::EXC_SELFTST_BIT] = 1'b1;
    end
    if (st.swReq) begin
      next_st.excStatus[purs_pkg::EXC_SWRST_BIT] = 1'b1;
    end
    if (st.extSeen) begin
      next_st.excStatus[purs_pkg::EXC_EXTRST_BIT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st           <= '0;
      st.phase     <= purs_pkg::PURS_WAIT_SUPPLY;
      st.warmLow   <= 1'b1;
      st.cpuRst    <= 1'b1;
      st.hiZ       <= 1'b1;
      st.excStatus <= purs_pkg::EXC_RESET;
      st.glbStatus <= purs_pkg::GLB_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Open drain: output always low, enable when pulling
  assign warm_reset_pin_n_out = 1'b0;
  assign warm_reset_pin_n_oe  = st.pinDrive;
  assign cpuReset   = st.cpuRst;
  assign outputsHiZ = st.hiZ;
  assign prdata     = st.rdata;
  assign pready     = st.ready;
  assign pslverr    = st.slverr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_bank_done;
    st.phase == purs_pkg::PURS_BANK_UP && st.phaseCnt == 12'(BANK_UP_CYC - 1);
  endsequence

  AST_OSC_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
    st.phase == purs_pkg::PURS_FUSE_LOAD && $past(st.phase) != purs_pkg::PURS_FUSE_LOAD
      |-> $past(st.phase) == purs_pkg::PURS_OSC_CHECK && $past(st.phaseCnt) == 12'(OSC_CHECK_CYC - 1))
    else $error("fuse phase entered without full oscillator check");
  AST_PUMP_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
    st.phase == purs_pkg::PURS_PUMP_UP && $past(st.phase) != purs_pkg::PURS_PUMP_UP
      |-> $past(st.phaseCnt) == 12'(FUSE_LOAD_CYC - 1))
    else $error("pump phase entered early");
  AST_CPU_HELD: assert property (@(posedge clk) disable iff (sys_rst)
    st.phase != purs_pkg::PURS_RUN |-> cpuReset && warm_reset_pin_n_oe == ~st.hiZ)
    else $error("reset released during power-up phases");
  AST_BANK_RUN: assert property (@(posedge clk) disable iff (sys_rst)
    s_bank_done and supplyOk |=> st.phase == purs_pkg::PURS_RUN)
    else $error("run not reached after bank phase");
  AST_START_GATE: assert property (@(posedge clk) disable iff (sys_rst)
    st.phase == purs_pkg::PURS_WAIT_SUPPLY && !supplyOk |=> st.phase == purs_pkg::PURS_WAIT_SUPPLY)
    else $error("sequence started without supplies");
  AST_PWRUP_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
    !supplyOk |=> st.excStatus[purs_pkg::EXC_POWERUP_BIT])
    else $error("power-up flag not set");
  AST_SW_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
    st.swReq |=> st.excStatus[purs_pkg::EXC_SWRST_BIT] && cpuReset)
    else $error("software reset not recorded");
  AST_OTHER_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    st.phase == purs_pkg::PURS_RUN && resetEvents.watchdog |=> st.warmLow [*8])
    else $error("warm reset pulse too short");
  AST_HIZ: assert property (@(posedge clk) disable iff (sys_rst)
    !core_power_good |=> outputsHiZ && !warm_reset_pin_n_oe)
    else $error("outputs not tristated on core fault");

endmodule

// ==== verif/purs_board_model.sv ====
// Board side: supply supervisor, reset supervisor and pulled-up warm reset wire
`timescale 1ns/1ps
module purs_board_model (
  input  wire logic coreOk,
  input  wire logic ioOk,
  input  wire logic porHold,
  input  wire logic extPull,
  input  wire logic devOut,
  input  wire logic devOe,
  output logic      core_power_good,
  output logic      io_power_good,
  output logic      power_on_reset_in_n,
  output logic      warmPin
);
  // Rail monitors report each supply
  assign core_power_good = coreOk;
  assign io_power_good   = ioOk;
  // Power-on reset held low while any rail is out of range
  assign power_on_reset_in_n = coreOk & ioOk & ~porHold;
  // Open-drain wire with pullup, idles high
  assign warmPin = ~(extPull | (devOe & ~devOut));
endmodule

// ==== verif/power_up_reset_sequencer_bench.sv ====
// Self-checking bench for the power-up reset sequencer
`timescale 1ns/1ps
module power_up_reset_sequencer_bench;
  localparam int OSC_C = 12, FUSE_C = 10, PUMP_C = 9, BANK_C = 8, WARM_C = 30, DIV = 4;
  localparam int TOTAL = OSC_C + FUSE_C + PUMP_C + BANK_C;
  localparam int HOLD  = purs_pkg::WARM_OTHER_PCLK * DIV;
  typedef struct { logic [31:0] data; logic [31:0] mask; logic err; } purs_note_t;
  logic                    clk, sys_rst, coreOk, ioOk, porHold, extPull, debugReset;
  logic                    corePg, ioPg, porN, warmPin, pinOut, pinOe, cpuReset, outputsHiZ, pready, pslverr;
  logic [31:0]             prdata, d;
  purs_pkg::purs_events_t  resetEvents;
  purs_pkg::purs_apb_req_t apbReq;
  purs_note_t              notes[$];
  purs_note_t              nt;
  int                      n_fail, num_checks, b;
  logic [11:0]             addrTab[8];
  int                      bitTab[8];

  purs_board_model board_u (.coreOk(coreOk), .ioOk(ioOk), .porHold(porHold), .extPull(extPull),
    .devOut(pinOut), .devOe(pinOe), .core_power_good(corePg), .io_power_good(ioPg),
    .power_on_reset_in_n(porN), .warmPin(warmPin));
  purs_sequencer #(.OSC_CHECK_CYC(OSC_C), .FUSE_LOAD_CYC(FUSE_C), .PUMP_UP_CYC(PUMP_C),
    .BANK_UP_CYC(BANK_C), .WARM_POR_CYC(WARM_C), .PCLK_DIV(DIV)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .power_on_reset_in_n(porN), .core_power_good(corePg), .io_power_good(ioPg),
    .warm_reset_pin_n_in(warmPin), .warm_reset_pin_n_out(pinOut), .warm_reset_pin_n_oe(pinOe),
    .resetEvents(resetEvents), .debugReset(debugReset), .cpuReset(cpuReset), .outputsHiZ(outputsHiZ),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Clock, 100 ns period
  always #50 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Answer monitor: oldest note against each pready
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) chk(32'h1, 32'h0);
      else begin
        nt = notes.pop_front();
        chk(prdata & nt.mask, nt.data & nt.mask);
        chk({31'h0, pslverr}, {31'h0, nt.err});
      end
    end
  end

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] exp,
                     input logic [31:0] m, input logic err, output logic [31:0] rd);
    int i;
    @(posedge clk);
    notes.push_back('{exp, m, err});
    apbReq <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
    rd = prdata;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  // Waits out a power-up, polling the phase register meanwhile
  task automatic seq_up();
    int cyc, bad, holes;
    logic [2:0]  last;
    logic [31:0] r;
    bad = 0;
    holes = 0;
    last = 3'h0;
    fork
      for (int i = 0; i < 60 && last != 3'h5; i++) begin
        apb(1'b0, purs_pkg::ADDR_SEQ_STATUS, 32'h0, 32'h0, 32'h0, 1'b0, r);
        if (r[2:0] !== last && r[2:0] !== last + 3'h1) bad++;
        last = r[2:0];
      end
      for (cyc = 0; cyc < 300 && cpuReset !== 1'b0; cyc++) begin
        @(posedge clk);
        if (cpuReset === 1'b1 && outputsHiZ === 1'b0 && pinOe !== 1'b1) holes++;
      end
    join
    chk(cyc >= TOTAL && cyc <= TOTAL + 16, 1);
    chk(bad, 0);
    chk(last, 5);
    chk(holes, 0);
    chk(pinOe, 0);
  endtask

  // Counts cycles with any reset activity
  task automatic quiet(input int n, output int busy);
    busy = 0;
    repeat (n) begin
      @(posedge clk);
      if (cpuReset !== 1'b0 || pinOe !== 1'b0) busy++;
    end
  endtask

  // Fires reset cause k, measures the pin drive, then checks and clears its flag
  task automatic ev_reset(input int k);
    int i, n;
    case (k)
      0, 1, 2, 3, 4: begin
        resetEvents <= 5'h10 >> k;
        @(posedge clk);
        resetEvents <= '0;
      end
      5: begin
        debugReset <= 1'b1;
        @(posedge clk);
        debugReset <= 1'b0;
      end
      6: apb(1'b1, purs_pkg::ADDR_RESET_CTRL, 32'h1 << purs_pkg::CTRL_SWRST_BIT, 0, 0, 1'b0, d);
      default: begin
        extPull <= 1'b1;
        repeat (21) @(posedge clk);
        extPull <= 1'b0;
      end
    endcase
    for (i = 0; i < 40 && pinOe !== 1'b1; i++) @(posedge clk);
    for (n = 0; n < 400 && pinOe === 1'b1; n++) @(posedge clk);
    if (k < 7) chk(n >= HOLD, 1);
    else chk(n > 0, 1);
    for (i = 0; i < 400 && cpuReset !== 1'b0; i++) @(posedge clk);
    if (i == 400) begin
      n_fail++;
      print_verdict();
    end
    apb(1'b0, addrTab[k], 0, 32'h1 << bitTab[k], 32'h1 << bitTab[k], 1'b0, d);
    apb(1'b1, addrTab[k], 32'h1 << bitTab[k], 0, 0, 1'b0, d);
    apb(1'b0, addrTab[k], 0, 0, 32'h1 << bitTab[k], 1'b0, d);
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {coreOk, ioOk, porHold, extPull, debugReset} = '0;
    resetEvents = '0;
    apbReq = '0;
    addrTab = '{purs_pkg::ADDR_GLB_STATUS, purs_pkg::ADDR_GLB_STATUS, purs_pkg::ADDR_GLB_STATUS,
                purs_pkg::ADDR_EXC_STATUS, purs_pkg::ADDR_EXC_STATUS, purs_pkg::ADDR_EXC_STATUS,
                purs_pkg::ADDR_EXC_STATUS, purs_pkg::ADDR_EXC_STATUS};
    bitTab = '{0, 8, 9, 13, 5, 13, 4, 3};
    void'($urandom(32'h0169));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    ioOk <= 1'b1;
    repeat (8) @(posedge clk);
    chk(outputsHiZ, 1);
    chk(cpuReset, 1);
    coreOk <= 1'b1;
    seq_up();
    apb(1'b0, purs_pkg::ADDR_EXC_STATUS, 0, 32'h8000, 32'h8000, 1'b0, d);
    apb(1'b1, purs_pkg::ADDR_EXC_STATUS, 32'h8000, 0, 0, 1'b0, d);
    apb(1'b1, purs_pkg::ADDR_SEQ_STATUS, $urandom(), 0, 0, 1'b0, d);
    apb(1'b0, purs_pkg::ADDR_SEQ_STATUS, 0, 32'h5, 32'h1F, 1'b0, d);
    apb(1'b0, 12'h010, 0, 0, 0, 1'b1, d);
    for (int k = 0; k < 8; k++) ev_reset(k);
    // Short lows on both reset inputs are ignored
    porHold <= 1'b1;
    repeat ($urandom_range(1, 4)) @(posedge clk);
    porHold <= 1'b0;
    quiet(20, b);
    chk(b, 0);
    extPull <= 1'b1;
    repeat ($urandom_range(1, 4)) @(posedge clk);
    extPull <= 1'b0;
    quiet(20, b);
    chk(b, 0);
    apb(1'b0, purs_pkg::ADDR_EXC_STATUS, 0, 0, 32'h8, 1'b0, d);
    // Long power-on low restarts the sequence
    porHold <= 1'b1;
    repeat (21) @(posedge clk);
    chk(cpuReset, 1);
    porHold <= 1'b0;
    seq_up();
    apb(1'b0, purs_pkg::ADDR_EXC_STATUS, 0, 32'h8000, 32'h8000, 1'b0, d);
    // Supply loss on each rail in turn, core first
    coreOk <= 1'b0;
    repeat (3) @(posedge clk);
    chk(outputsHiZ, 1);
    chk(pinOe, 0);
    coreOk <= 1'b1;
    ioOk <= 1'b0;
    repeat (10) @(posedge clk);
    chk(cpuReset, 1);
    ioOk <= 1'b1;
    seq_up();
    print_verdict();
  end

  // Run limit
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule
